// [rtl/ldqi_device.sv]
// Purpose: status, diagnostics, quality monitor and interrupt of a PHY
// Assumes: PHY core inputs share clock_in; pin passes two flip-flops
// Notes on behaviour
// - pin driven only if output enabled, unmasked
// - all sources disabled after reset
// - pin goes low at once on event
// - upper byte shows every pending source
// - status read clears all pending bits
// - host writes 0003h to interrupt control
// - host writes 0060h to unmask two sources
// - energy detect: low power, wake pulses
// - diagnostic registers only on page 2
// - polarity flag in two status registers
// - polarity valid only 10 Mb or negotiated
// - crossover shown in phy status bit
// - cable length valid at 100 with link
// - frequency offset or control, 100 link
// - 32-bit variance by two reads, period select
// - global enable, high/low warnings per parameter
// - variance high warning on upper half
// - threshold at range end never trips
// - quality warnings interrupt only when enabled
// - violation with auto enable restarts DSP
// - signal detect option 0 drops link
// - sample bit latches selected parameter value
// - equal to threshold gives no warning
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "ldqi_cfg.svh"
module ldqi_device (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   ldqi_if.device           mgmt,
   input  wire logic        link_up_in,
   input  wire logic        speed100_in,
   input  wire logic        autoneg100_in,
   input  wire logic        polarity_inv_in,
   input  wire logic        mdix_in,
   input  wire logic        energy_in,
   input  wire logic        signal_detect_option_in,
   input  wire logic [7:0]  cable_len_in,
   input  wire logic [39:0] params_in,
   input  wire logic [31:0] variance_in,
   output logic             low_power_out,
   output logic             wake_pulse_out,
   output logic             power_up_out,
   output logic             power_down_out,
   output logic             dsp_restart_out,
   output logic             link_status_out,
   output logic [1:0]       var_period_out
);
   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [7:0] pick(input logic [39:0] p,
                                       input logic [2:0]  sel);
      pick = p[8 * sel +: 8];
   endfunction : pick

   // strictly beyond the threshold; range ends can never trip
   function automatic logic beyond(input logic [7:0] v,
                                   input logic [7:0] t,
                                   input logic       sgn,
                                   input logic       hi);
      logic gt;
      logic lt;
      gt = sgn ? ($signed(v) > $signed(t)) : (v > t);
      lt = sgn ? ($signed(v) < $signed(t)) : (v < t);
      beyond = hi ? gt : lt;
   endfunction : beyond

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [1:0]  int_ctrl;
   logic [7:0]  int_mask;
   logic [7:0]  pending;
   logic [15:0] page;
   logic        ed_enable;
   logic        fo_sel_fc;
   logic [1:0]  var_ctrl;
   logic        var_second;
   logic [15:0] var_low_hold;
   logic        lq_enable;
   logic [4:0]  lq_auto;
   logic [9:0]  lq_warn;
   logic        lv_warn;
   logic        lv_auto;
   logic [7:0]  sample;
   logic [7:0]  thr [0:9];
   logic [15:0] var_thr;
   logic        link_d;
   logic        low_power_d;
   logic        link_drop;
   logic [15:0] wake_cnt;
   logic [1:0]  pin_sync;
   logic [15:0] rdata;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire diag     = (page == `LDQI_PAGE_DIAG);
   wire wr_ic    = mgmt.wr & (mgmt.addr == `LDQI_A_INT_CTRL);
   wire wr_ism   = mgmt.wr & (mgmt.addr == `LDQI_A_INT_STATMASK);
   wire rd_ism   = mgmt.rd & (mgmt.addr == `LDQI_A_INT_STATMASK);
   wire wr_page  = mgmt.wr & (mgmt.addr == `LDQI_A_PAGE_SELECT);
   wire wr_ed    = mgmt.wr & ~diag & (mgmt.addr == `LDQI_A_ENERGY_CTRL);
   wire wr_fo    = mgmt.wr & diag & (mgmt.addr == `LDQI_A_FREQ_OFFSET);
   wire wr_vc    = mgmt.wr & diag & (mgmt.addr == `LDQI_A_VAR_CTRL);
   wire rd_vs    = mgmt.rd & diag & (mgmt.addr == `LDQI_A_VAR_SUM);
   wire wr_lq    = mgmt.wr & diag & (mgmt.addr == `LDQI_A_LQ_CTRL);
   wire rd_lq    = mgmt.rd & diag & (mgmt.addr == `LDQI_A_LQ_CTRL);
   wire wr_lv    = mgmt.wr & diag & (mgmt.addr == `LDQI_A_LQ_VARIANCE);
   wire rd_lv    = mgmt.rd & diag & (mgmt.addr == `LDQI_A_LQ_VARIANCE);
   wire wr_ld    = mgmt.wr & diag & (mgmt.addr == `LDQI_A_LQ_DATA);
   wire wr_vt    = mgmt.wr & diag & (mgmt.addr == `LDQI_A_VAR_THRESH);
   wire [2:0] ld_sel = mgmt.wdata[`LDQI_LD_SEL_LSB +: 3];
   wire [3:0] thr_ix = {ld_sel, mgmt.wdata[`LDQI_LD_THR_HIGH]};

   // ----------------------------------------------------------------
   // link state and diagnostics
   // ----------------------------------------------------------------
   wire fast_link = speed100_in & link_up_in;
   wire pol_ok    = polarity_inv_in & (~speed100_in | autoneg100_in);
   wire [7:0] len_v  = fast_link ? cable_len_in : 8'h00;
   wire [7:0] fo_raw = pick(params_in, fo_sel_fc ? 3'h4 : 3'h3);
   wire [7:0] fo_v   = fast_link ? fo_raw : 8'h00;

   // ----------------------------------------------------------------
   // quality monitor
   // ----------------------------------------------------------------
   logic [9:0] hit;
   always_comb begin
      for (int i = 0; i < `LDQI_NUM_THRESH; i++) begin
         hit[i] = lq_enable & fast_link &
                  beyond(pick(params_in, 3'(i / 2)), thr[i],
                         3'(i / 2) != `LDQI_GAIN_INDEX,
                         1'(i % 2));
      end
   end
   wire var_hit = lq_enable & fast_link &
                  (variance_in[31:16] > var_thr);
   logic [4:0] auto_hit;
   always_comb begin
      for (int p = 0; p < `LDQI_NUM_PARAMS; p++) begin
         auto_hit[p] = lq_auto[p] & (hit[2 * p] | hit[2 * p + 1]);
      end
   end
   wire restart = (|auto_hit) | (lv_auto & var_hit);
   wire lq_event = (|(hit & ~lq_warn)) | (var_hit & ~lv_warn);

   // ----------------------------------------------------------------
   // interrupt sources
   // ----------------------------------------------------------------
   wire [7:0] events = {lq_event, (energy_in != low_power_d) & ed_enable,
                        link_up_in != link_d, 5'h00};
   wire [7:0] live = (pending | events) & int_mask;
   wire irq_active = int_ctrl[`LDQI_IC_GEN_EN] & (|live);
   assign mgmt.dev_pin_out  = ~irq_active;
   assign mgmt.dev_pin_oe_n = ~(int_ctrl[`LDQI_IC_PIN_OE] & irq_active);
   assign power_down_out    = ~int_ctrl[`LDQI_IC_PIN_OE] & ~pin_sync[1];

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [15:0] next_rdata;
   always_comb begin
      next_rdata = 16'h0000;
      case (mgmt.addr)
         `LDQI_A_PHY_STATUS: begin
            next_rdata[`LDQI_PS_LINK]     = link_status_out;
            next_rdata[`LDQI_PS_SPEED10]  = ~speed100_in;
            next_rdata[`LDQI_PS_POLARITY] = pol_ok;
            next_rdata[`LDQI_PS_MDIX]     = mdix_in;
         end
         `LDQI_A_INT_CTRL:     next_rdata[1:0] = int_ctrl;
         `LDQI_A_INT_STATMASK: next_rdata = {pending, int_mask};
         `LDQI_A_PAGE_SELECT:  next_rdata = page;
         `LDQI_A_CABLE_LEN:    if (diag) next_rdata[7:0] = len_v;
         `LDQI_A_FREQ_OFFSET:  if (diag) next_rdata = {7'h00, fo_sel_fc, fo_v};
         `LDQI_A_TEN_MB_STAT: begin
            if (diag) next_rdata[2:1] = var_ctrl;
            else next_rdata[`LDQI_TB_POLARITY] = pol_ok;
         end
         `LDQI_A_VAR_SUM: begin
            if (diag) next_rdata = var_second ? var_low_hold
                                              : variance_in[31:16];
         end
         `LDQI_A_LQ_VARIANCE: begin
            if (diag) next_rdata[1:0] = {lv_auto, lv_warn};
         end
         `LDQI_A_ENERGY_CTRL: begin
            if (diag) next_rdata = {lq_enable, lq_auto, lq_warn};
            else next_rdata[`LDQI_ED_ENABLE] = ed_enable;
         end
         `LDQI_A_LQ_DATA:      if (diag) next_rdata[7:0] = sample;
         `LDQI_A_VAR_THRESH:   if (diag) next_rdata = var_thr;
         default:              next_rdata = 16'h0000;
      endcase
   end
   assign mgmt.rdata = rdata;

   // ----------------------------------------------------------------
   // interrupt, page and control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         int_ctrl <= 2'h0;
         int_mask <= 8'h00;
         pending  <= 8'h00;
         page     <= 16'h0000;
         rdata    <= 16'h0000;
         pin_sync <= 2'h3;
      end else begin
         pin_sync <= {pin_sync[0], mgmt.pin_level};
         rdata    <= mgmt.rd ? next_rdata : 16'h0000;
         if (wr_ic) int_ctrl <= mgmt.wdata[1:0];
         if (wr_ism) int_mask <= mgmt.wdata[7:0];
         if (wr_page) page <= mgmt.wdata;
         // new events win over the clearing read
         pending <= (rd_ism ? 8'h00 : pending) | events;
      end
   end

   // ----------------------------------------------------------------
   // energy detect, link and variance
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ed_enable    <= 1'b0;
         fo_sel_fc    <= 1'b0;
         var_ctrl     <= 2'h0;
         var_second   <= 1'b0;
         var_low_hold <= 16'h0000;
         link_d       <= 1'b0;
         low_power_d  <= 1'b0;
         link_drop    <= 1'b0;
         wake_cnt     <= 16'h0000;
      end else begin
         if (wr_ed) ed_enable <= mgmt.wdata[`LDQI_ED_ENABLE];
         if (wr_fo) fo_sel_fc <= mgmt.wdata[`LDQI_FO_SELECT_FC];
         if (wr_vc) var_ctrl <= mgmt.wdata[2:1];
         if (wr_vc) var_second <= 1'b0;
         else if (rd_vs) var_second <= ~var_second;
         if (rd_vs && !var_second) var_low_hold <= variance_in[15:0];
         link_d      <= link_up_in;
         low_power_d <= energy_in;
         if (!link_up_in) link_drop <= 1'b0;
         else if (restart && !signal_detect_option_in) begin
            link_drop <= 1'b1;
         end
         if (!low_power_out || wake_cnt == 16'(`LDQI_ED_WAKE_CYC - 1)) begin
            wake_cnt <= 16'h0000;
         end else begin
            wake_cnt <= wake_cnt + 16'h0001;
         end
      end
   end
   assign low_power_out   = ed_enable & ~energy_in;
   assign wake_pulse_out  = low_power_out &
                            (wake_cnt == 16'(`LDQI_ED_WAKE_CYC - 1));
   assign power_up_out    = ed_enable & energy_in & ~low_power_d;
   assign dsp_restart_out = restart;
   assign link_status_out = link_up_in & ~link_drop;
   assign var_period_out  = var_ctrl;

   // ----------------------------------------------------------------
   // quality monitor registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         lq_enable <= 1'b0;
         lq_auto   <= 5'h00;
         lq_warn   <= 10'h000;
         lv_warn   <= 1'b0;
         lv_auto   <= 1'b0;
         sample    <= 8'h00;
         var_thr   <= `LDQI_VAR_THR_MAX;
         for (int i = 0; i < `LDQI_NUM_THRESH; i++) begin
            if (3'(i / 2) == `LDQI_GAIN_INDEX) begin
               thr[i] <= (i % 2 == 1) ? `LDQI_U_MAX : `LDQI_U_MIN;
            end else begin
               thr[i] <= (i % 2 == 1) ? `LDQI_S_MAX : `LDQI_S_MIN;
            end
         end
      end else begin
         if (wr_lq) begin
            lq_enable <= mgmt.wdata[`LDQI_LQ_GLOBAL_EN];
            lq_auto   <= mgmt.wdata[14:`LDQI_LQ_AUTO_LSB];
         end
         if (wr_lv) lv_auto <= mgmt.wdata[`LDQI_LV_AUTO];
         lq_warn <= (rd_lq ? 10'h000 : lq_warn) | hit;
         lv_warn <= (rd_lv ? 1'b0 : lv_warn) | var_hit;
         if (wr_ld && mgmt.wdata[`LDQI_LD_SAMPLE]) begin
            sample <= pick(params_in, ld_sel);
         end
         if (wr_ld && mgmt.wdata[`LDQI_LD_THR_WRITE] &&
             thr_ix < 4'(`LDQI_NUM_THRESH)) begin
            thr[thr_ix] <= mgmt.wdata[7:0];
         end
         if (wr_vt) var_thr <= mgmt.wdata;
      end
   end
endmodule : ldqi_device

// [rtl/ldqi_host.sv]
// Purpose: host end: enables interrupts, then relays user accesses
// Assumes: user strobes one cycle, never both at once
// Notes:   user accesses refused while busy_out is high
`timescale 1ns/1ps
`include "ldqi_cfg.svh"
module ldqi_host (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   ldqi_if.host             mgmt,
   input  wire logic [4:0]  user_addr_in,
   input  wire logic [15:0] user_wdata_in,
   input  wire logic        user_wr_in,
   input  wire logic        user_rd_in,
   output logic [15:0]      user_rdata_out,
   output logic             user_rvalid_out,
   output logic             busy_out,
   output logic             irq_out
);
   ldqi_pkg::ldqi_host_state_t state;
   ldqi_pkg::ldqi_host_state_t next_state;
   logic [1:0]  pin_sync;
   logic        rd_d;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;

   // ----------------------------------------------------------------
   // init sequence
   // ----------------------------------------------------------------
   wire ready = (state == ldqi_pkg::LDQI_H_READY);
   always_comb begin
      case (state)
         ldqi_pkg::LDQI_H_INIT_CTRL: next_state = ldqi_pkg::LDQI_H_INIT_MASK;
         ldqi_pkg::LDQI_H_INIT_MASK: next_state = ldqi_pkg::LDQI_H_READY;
         ldqi_pkg::LDQI_H_READY:     next_state = ldqi_pkg::LDQI_H_READY;
         default:                    next_state = ldqi_pkg::LDQI_H_INIT_CTRL;
      endcase
   end

   // ----------------------------------------------------------------
   // bus drive
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state          <= ldqi_pkg::LDQI_H_INIT_CTRL;
         addr           <= 5'h00;
         wdata          <= 16'h0000;
         wr             <= 1'b0;
         rd             <= 1'b0;
         rd_d           <= 1'b0;
         user_rdata_out <= 16'h0000;
         pin_sync       <= 2'h3;
      end else begin
         state    <= next_state;
         pin_sync <= {pin_sync[0], mgmt.pin_level};
         rd_d     <= rd;
         if (rd_d) user_rdata_out <= mgmt.rdata;
         case (state)
            ldqi_pkg::LDQI_H_INIT_CTRL: begin
               addr  <= `LDQI_A_INT_CTRL;
               wdata <= `LDQI_HOST_CTRL_VAL;
               wr    <= 1'b1;
               rd    <= 1'b0;
            end
            ldqi_pkg::LDQI_H_INIT_MASK: begin
               addr  <= `LDQI_A_INT_STATMASK;
               wdata <= `LDQI_HOST_MASK_VAL;
               wr    <= 1'b1;
               rd    <= 1'b0;
            end
            default: begin
               // page select and paired variance reads come from the user
               addr  <= user_addr_in;
               wdata <= user_wdata_in;
               wr    <= user_wr_in;
               rd    <= user_rd_in;
            end
         endcase
      end
   end

   assign mgmt.addr          = addr;
   assign mgmt.wdata         = wdata;
   assign mgmt.wr            = wr;
   assign mgmt.rd            = rd;
   assign mgmt.host_pin_out  = 1'b1;
   assign mgmt.host_pin_oe_n = 1'b1;
   assign user_rvalid_out    = rd_d;
   assign busy_out           = ~ready;
   assign irq_out            = ~pin_sync[1];
endmodule : ldqi_host

// [shared/ldqi_cfg.svh]
// Purpose: constants of the link diagnostic and interrupt block
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   offsets are register indices on the management port
`ifndef LDQI_CFG_SVH
`define LDQI_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LDQI_A_PHY_STATUS   5'h10
`define LDQI_A_INT_CTRL     5'h11
`define LDQI_A_INT_STATMASK 5'h12
`define LDQI_A_PAGE_SELECT  5'h13
`define LDQI_A_CABLE_LEN    5'h14
`define LDQI_A_FREQ_OFFSET  5'h15
`define LDQI_A_TEN_MB_STAT  5'h1A
`define LDQI_A_VAR_CTRL     5'h1A
`define LDQI_A_VAR_SUM      5'h1B
`define LDQI_A_LQ_VARIANCE  5'h1C
`define LDQI_A_ENERGY_CTRL  5'h1D
`define LDQI_A_LQ_CTRL      5'h1D
`define LDQI_A_LQ_DATA      5'h1E
`define LDQI_A_VAR_THRESH   5'h1F
`define LDQI_PAGE_DIAG      16'h0002

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LDQI_IC_PIN_OE      0
`define LDQI_IC_GEN_EN      1
`define LDQI_SRC_LINK       5
`define LDQI_SRC_ENERGY     6
`define LDQI_SRC_QUALITY    7
`define LDQI_PENDING_LSB    8
`define LDQI_PS_LINK        0
`define LDQI_PS_SPEED10     1
`define LDQI_PS_POLARITY    12
`define LDQI_PS_MDIX        14
`define LDQI_TB_POLARITY    4
`define LDQI_ED_ENABLE      15
`define LDQI_FO_SELECT_FC   8
`define LDQI_LQ_GLOBAL_EN   15
`define LDQI_LQ_AUTO_LSB    10
`define LDQI_LV_WARN        0
`define LDQI_LV_AUTO        1
`define LDQI_LD_SAMPLE      13
`define LDQI_LD_THR_WRITE   12
`define LDQI_LD_THR_HIGH    8
`define LDQI_LD_SEL_LSB     9
`define LDQI_GAIN_INDEX     3'h1
`define LDQI_NUM_PARAMS     5
`define LDQI_NUM_THRESH     10

// ----------------------------------------------------------------
// reset values and host orders
// ----------------------------------------------------------------
`define LDQI_S_MIN          8'h80
`define LDQI_S_MAX          8'h7F
`define LDQI_U_MIN          8'h00
`define LDQI_U_MAX          8'hFF
`define LDQI_VAR_THR_MAX    16'hFFFF
`define LDQI_HOST_CTRL_VAL  16'h0003
`define LDQI_HOST_MASK_VAL  16'h0060

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LDQI_CLK_NS         50
`define LDQI_ED_WAKE_US     50
`define LDQI_ED_WAKE_CYC    ((`LDQI_ED_WAKE_US * 1000) / `LDQI_CLK_NS)

`endif

// [shared/ldqi_if.sv]
// Purpose: management port and shared interrupt pin between the ends
// Assumes: one clock, read data one cycle after the read strobe
// Notes:   pin resolved here, pulled high when nobody drives low
`timescale 1ns/1ps
interface ldqi_if;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        dev_pin_out;
   logic        dev_pin_oe_n;
   logic        host_pin_out;
   logic        host_pin_oe_n;
   logic        pin_level;

   // wired-low pin with weak pull-up
   assign pin_level = ~((~dev_pin_oe_n & ~dev_pin_out) |
                        (~host_pin_oe_n & ~host_pin_out));

   modport device (
      input  addr, wdata, wr, rd, pin_level,
      output rdata, dev_pin_out, dev_pin_oe_n
   );
   modport host (
      input  rdata, pin_level,
      output addr, wdata, wr, rd, host_pin_out, host_pin_oe_n
   );
endinterface : ldqi_if

// [shared/ldqi_pkg.sv]
// Purpose: types of the link diagnostic and interrupt block
// Assumes: nothing
// Notes:   constants live in ldqi_cfg.svh
package ldqi_pkg;
   typedef enum logic [1:0] {
      LDQI_H_INIT_CTRL = 2'b00,
      LDQI_H_INIT_MASK = 2'b01,
      LDQI_H_READY     = 2'b10
   } ldqi_host_state_t;
endpackage : ldqi_pkg

// [tb/ldqi_props.sv]
// Purpose: checks on the management port and interrupt pin
// Assumes: one clock, sync active-low reset
// Notes:   control, mask and page shadows follow the writes
`timescale 1ns/1ps
`include "ldqi_cfg.svh"
module ldqi_props (
   input wire logic        clock_in,
   input wire logic        rst_n_in,
   input wire logic [4:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        dev_pin_out,
   input wire logic        dev_pin_oe_n,
   input wire logic        pin_level
);
   logic [15:0] ctrl;
   logic [15:0] mask;
   logic [15:0] page;
   wire         rd_sm  = rd && addr == `LDQI_A_INT_STATMASK;
   wire         gen_on = ctrl[`LDQI_IC_PIN_OE] && ctrl[`LDQI_IC_GEN_EN];
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ctrl <= 16'h0000;
         mask <= 16'h0000;
         page <= 16'h0000;
      end else if (wr) begin
         if (addr == `LDQI_A_INT_CTRL) ctrl <= wdata;
         if (addr == `LDQI_A_INT_STATMASK) mask <= wdata;
         if (addr == `LDQI_A_PAGE_SELECT) page <= wdata;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_pin_only_low: assert property (!dev_pin_oe_n |-> !dev_pin_out)
      else $error("pin driven high");
   a_pin_needs_ctrl: assert property (!gen_on |-> pin_level)
      else $error("pin low while output disabled");
   a_pin_needs_mask: assert property (mask[7:5] == 3'h0 |-> pin_level)
      else $error("pin low while all masked");
   a_quiet_reset: assert property ($rose(rst_n_in) |-> pin_level [*3])
      else $error("pin low after reset");
   a_ctrl_echo: assert property (rd && addr == `LDQI_A_INT_CTRL
      |=> rdata[1:0] == ctrl[1:0]) else $error("control readback");
   a_mask_echo: assert property (rd_sm |=> rdata[7:5] == mask[7:5])
      else $error("mask readback");
   a_pin_holds: assert property (!pin_level && !rd_sm && !wr
      |=> !pin_level) else $error("pin released early");
   a_page_gate: assert property (page != `LDQI_PAGE_DIAG && rd
      && addr == `LDQI_A_CABLE_LEN |=> rdata == 16'h0000)
      else $error("diagnostic visible off page");
   a_pending_shown: assert property ($past(!pin_level) && !pin_level
      && !$past(rd) && rd_sm |=> (rdata[15:8] & rdata[7:0]) != 8'h00)
      else $error("pending source not shown");
endmodule : ldqi_props

// [tb/test_link_diag_quality_interrupt.sv]
// Purpose: end-to-end test of host and device ends
// Assumes: 20 MHz clock, sync active-low reset
// Notes:   registers reached through the host user port
`timescale 1ns/1ps
`include "ldqi_cfg.svh"
module test_link_diag_quality_interrupt;
   logic        clock_in = 0;
   logic        rst_n_in = 0;
   logic [4:0]  ua = 5'h00;
   logic [15:0] uw = 16'h0000;
   logic        uwr = 0;
   logic        urd = 0;
   logic [15:0] urdata;
   logic        urv, busy, irq, lp, wk, pu, pd, dsp, lnk;
   logic [1:0]  vp;
   logic        lup = 0, s100 = 1, an = 0, pol = 1, mdx = 1, en = 0, sdo = 1;
   logic [7:0]  cl = 8'h5A;
   logic [39:0] prm = 40'h9A_33_C3_FF_10;
   int          n_fail = 0;
   int          checks_done = 0;
   int          k = 0;
   ldqi_if bus ();
   ldqi_device ldqi_device_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .mgmt(bus), .link_up_in(lup), .speed100_in(s100), .autoneg100_in(an),
      .polarity_inv_in(pol), .mdix_in(mdx), .energy_in(en),
      .signal_detect_option_in(sdo), .cable_len_in(cl), .params_in(prm),
      .variance_in(32'h1234_5678), .low_power_out(lp), .wake_pulse_out(wk),
      .power_up_out(pu), .power_down_out(pd), .dsp_restart_out(dsp),
      .link_status_out(lnk), .var_period_out(vp));
   ldqi_host ldqi_host_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .mgmt(bus), .user_addr_in(ua), .user_wdata_in(uw), .user_wr_in(uwr),
      .user_rd_in(urd), .user_rdata_out(urdata), .user_rvalid_out(urv),
      .busy_out(busy), .irq_out(irq));
   ldqi_props ldqi_props_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
      .rdata(bus.rdata), .dev_pin_out(bus.dev_pin_out),
      .dev_pin_oe_n(bus.dev_pin_oe_n), .pin_level(bus.pin_level));
   always #25 clock_in = ~clock_in;
   task automatic chk(input string nm, input logic [15:0] s, e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic w(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock_in);
      ua <= a;
      uw <= d;
      uwr <= 1;
      @(posedge clock_in);
      uwr <= 0;
   endtask : w
   // read, then compare the masked data
   task automatic r(input logic [4:0] a, input logic [15:0] m, e);
      int i;
      @(posedge clock_in);
      ua <= a;
      urd <= 1;
      @(posedge clock_in);
      urd <= 0;
      #1;
      for (i = 0; i < 8 && urv !== 1'b1; i++) tick(1);
      if (i == 8) begin
         n_fail++;
         finish_test();
      end
      tick(1);
      chk("rdata", urdata & m, e);
   endtask : r
   initial begin
      tick(5);
      @(posedge clock_in) rst_n_in <= 1;
      tick(3);
      chk("busy", 16'(busy), 16'h0000);
      chk("pin", 16'(bus.pin_level), 16'h0001);
      r(`LDQI_A_INT_CTRL, 16'hFFFF, 16'h0003);
      r(`LDQI_A_INT_STATMASK, 16'hFFFF, 16'h0060);
      @(posedge clock_in) lup <= 1;
      #1 chk("pin", 16'(bus.pin_level), 16'h0000);
      tick(4);
      chk("irq", 16'(irq), 16'h0001);
      r(`LDQI_A_INT_STATMASK, 16'hFF00, 16'h2000);
      chk("pin", 16'(bus.pin_level), 16'h0001);
      w(`LDQI_A_ENERGY_CTRL, 16'h8000);
      repeat (2050) begin
         tick(1);
         k += wk;
      end
      chk("wake", 16'(k), 16'h0002);
      chk("lowpwr", 16'(lp), 16'h0001);
      @(posedge clock_in) en <= 1;
      lup <= 0;
      #1 chk("powerup", 16'(pu), 16'h0001);
      r(`LDQI_A_INT_STATMASK, 16'hFF00, 16'h6000);
      $display("test interrupt done");
      w(`LDQI_A_INT_STATMASK, 16'h0000);
      @(posedge clock_in) lup <= 1;
      tick(3);
      chk("pin", 16'(bus.pin_level), 16'h0001);
      r(`LDQI_A_INT_STATMASK, 16'hFF00, 16'h2000);
      w(`LDQI_A_INT_CTRL, 16'h0002);
      w(`LDQI_A_INT_STATMASK, 16'h0060);
      @(posedge clock_in) lup <= 0;
      tick(3);
      chk("pin", 16'(bus.pin_level), 16'h0001);
      chk("pwrdown", 16'(pd), 16'h0000);
      w(`LDQI_A_INT_CTRL, 16'h0003);
      tick(1);
      chk("pin", 16'(bus.pin_level), 16'h0000);
      r(`LDQI_A_INT_STATMASK, 16'hFF00, 16'h2000);
      $display("test masking done");
      r(`LDQI_A_PHY_STATUS, 16'h5000, 16'h4000);
      @(posedge clock_in) an <= 1;
      r(`LDQI_A_PHY_STATUS, 16'h5000, 16'h5000);
      r(`LDQI_A_TEN_MB_STAT, 16'h0010, 16'h0010);
      r(`LDQI_A_CABLE_LEN, 16'hFFFF, 16'h0000);
      w(`LDQI_A_PAGE_SELECT, `LDQI_PAGE_DIAG);
      r(`LDQI_A_CABLE_LEN, 16'hFFFF, 16'h0000);
      @(posedge clock_in) lup <= 1;
      r(`LDQI_A_CABLE_LEN, 16'h00FF, 16'h005A);
      r(`LDQI_A_FREQ_OFFSET, 16'h00FF, 16'h0033);
      w(`LDQI_A_FREQ_OFFSET, 16'h0100);
      r(`LDQI_A_FREQ_OFFSET, 16'h00FF, 16'h009A);
      w(`LDQI_A_VAR_CTRL, 16'h0006);
      tick(1);
      chk("period", 16'(vp), 16'h0003);
      r(`LDQI_A_VAR_SUM, 16'hFFFF, 16'h1234);
      r(`LDQI_A_VAR_SUM, 16'hFFFF, 16'h5678);
      w(`LDQI_A_LQ_DATA, 16'h2400);
      r(`LDQI_A_LQ_DATA, 16'h00FF, 16'h00C3);
      $display("test status done");
      r(`LDQI_A_INT_STATMASK, 16'hFF00, 16'h2000);
      w(`LDQI_A_LQ_CTRL, 16'h8800);
      tick(3);
      r(`LDQI_A_LQ_CTRL, 16'h03FF, 16'h0000);
      w(`LDQI_A_LQ_DATA, 16'h1340);
      @(posedge clock_in) prm[15:8] <= 8'h40;
      tick(3);
      r(`LDQI_A_LQ_CTRL, 16'h03FF, 16'h0000);
      chk("restart", 16'(dsp), 16'h0000);
      @(posedge clock_in) prm[15:8] <= 8'h41;
      sdo <= 0;
      tick(3);
      chk("restart", 16'(dsp), 16'h0001);
      chk("link", 16'(lnk), 16'h0000);
      r(`LDQI_A_LQ_CTRL, 16'h83FF, 16'h8008);
      r(`LDQI_A_INT_STATMASK, 16'h8000, 16'h8000);
      $display("test quality done");
      finish_test();
   end
endmodule : test_link_diag_quality_interrupt
